// file: status_led_pkg.sv
// Constants, field layouts and types shared by the status indicator block.
// Assumes a 200 MHz system clock and a 32-bit AHB-Lite register bus.
package status_led_pkg;

    // ==========================================================
    // Timing
    localparam int CLK_KHZ = 200_000;
    localparam int BLINK_HALF_MS = 500;
    localparam int BLINK_HALF_CYC = BLINK_HALF_MS * CLK_KHZ;
    localparam int LAMP_STEP_MS = 500;
    localparam int LAMP_STEP_CYC = LAMP_STEP_MS * CLK_KHZ;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFS_COND = 8'h00;
    localparam logic [7:0] OFS_STATE = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h0c;
    localparam logic [7:0] OFS_IRQ_EN = 8'h10;
    localparam logic [7:0] OFS_DHCP = 8'h14;
    localparam logic [7:0] OFS_BOOTP = 8'h20;
    localparam logic [7:0] OFS_ACT = 8'h2c;

    // ==========================================================
    // Condition register fields
    localparam int COND_W = 9;
    localparam int BIT_CFG_VALID = 0;
    localparam int BIT_DUP_IP = 1;
    localparam int BIT_CONN_OPEN = 2;
    localparam int BIT_CONN_FAULT = 3;
    localparam int BIT_ERR_RECOV = 4;
    localparam int BIT_ERR_UNREC = 5;
    localparam int BIT_LBUS_FAULT = 6;
    localparam int BIT_DHCP_OK = 7;
    localparam int BIT_BOOTP_OK = 8;
    localparam logic [COND_W-1:0] COND_RST = 9'h000;

    // ==========================================================
    // Interrupt fields
    localparam int IRQ_W = 3;
    localparam int IRQ_INIT_DONE = 0;
    localparam int IRQ_MEM_FAIL = 1;
    localparam int IRQ_GREEN_LOST = 2;

    // ==========================================================
    // Fallback network words and self-test pattern
    localparam logic [31:0] DEF_IP = 32'hc0a8_0145;
    localparam logic [31:0] DEF_MASK = 32'hffff_ff00;
    localparam logic [31:0] DEF_GW = 32'h0000_0000;
    localparam logic [31:0] MEM_PATTERN = 32'ha5c3_5a3c;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        MODE_GREEN = 2'h0,
        MODE_FLASH_GREEN = 2'h1,
        MODE_FLASH_RED = 2'h2,
        MODE_RED = 2'h3
    } mode_t;

    typedef enum logic [4:0] {
        ST_LAMP_RED = 5'h01,
        ST_LAMP_GREEN = 5'h02,
        ST_MEM_WR = 5'h04,
        ST_MEM_RD = 5'h08,
        ST_RUN = 5'h10
    } state_t;

endpackage : status_led_pkg

// file: selftest_mem.sv
// Small single-port memory exercised by the start-up self-test.
// Assumes one clock; read data appear one cycle after the address.
module selftest_mem #(
    parameter int DEPTH = 16,
    parameter int WIDTH = 32
) (
    input wire logic hclk,
    input wire logic we,
    input wire logic [$clog2(DEPTH)-1:0] addr,
    input wire logic [WIDTH-1:0] wdata,
    output logic [WIDTH-1:0] rdata
);

    logic [WIDTH-1:0] mem [DEPTH];

    // ==========================================================
    // Storage with registered read port
    always_ff @(posedge hclk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr]; // Old data on a write cycle
    end

endmodule : selftest_mem

// file: status_led.sv
// Status indicator logic: three two-colour lamps, start-up test, address choice.
// Assumes an AHB-Lite master on hclk and firmware that writes the condition flags.
//
// The AHB-Lite slave port and the address map were decided locally.
module status_led #(
    parameter int BLINK_HALF = status_led_pkg::BLINK_HALF_CYC,
    parameter int LAMP_STEP = status_led_pkg::LAMP_STEP_CYC,
    parameter int MEM_DEPTH = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic irq,
    output logic ms_red,
    output logic ms_green,
    output logic ns_red,
    output logic ns_green,
    output logic lb_red,
    output logic lb_green
);

    localparam int AW = $clog2(MEM_DEPTH);

    if (BLINK_HALF < 1 || LAMP_STEP < 1 || MEM_DEPTH < 2) begin : g_bad_param
        $error("status_led: parameter out of range");
    end

    typedef struct packed {
        status_led_pkg::state_t st;
        logic [31:0] cnt;
        logic [31:0] blink_cnt;
        logic blink;
        logic [status_led_pkg::COND_W-1:0] cond;
        logic [2:0][31:0] dhcp;
        logic [2:0][31:0] bootp;
        logic [status_led_pkg::IRQ_W-1:0] irq_stat;
        logic [status_led_pkg::IRQ_W-1:0] irq_en;
        logic irq;
        logic mem_fail;
        logic chk_vld;
        logic [AW-1:0] chk_addr;
        logic prev_good;
        logic wr_pend;
        logic [5:0] wr_idx;
        logic rdy;
        logic [31:0] hrdata;
        logic [5:0] lamps;
    } regs_t;

    regs_t r;
    regs_t n;
    logic mem_we;
    logic [AW-1:0] mem_addr;
    logic [31:0] mem_wdata;
    logic [31:0] mem_rdata;
    logic all_good;

    // ==========================================================
    // Helpers
    function automatic status_led_pkg::mode_t severity(input logic red, input logic fr, input logic fg);
        if (red) begin
            return status_led_pkg::MODE_RED;
        end else if (fr) begin
            return status_led_pkg::MODE_FLASH_RED;
        end else if (fg) begin
            return status_led_pkg::MODE_FLASH_GREEN;
        end
        return status_led_pkg::MODE_GREEN;
    endfunction : severity

    // Returns {red, green}
    function automatic logic [1:0] drive(input status_led_pkg::mode_t m, input logic bl);
        case (m)
            status_led_pkg::MODE_RED: return 2'h2;
            status_led_pkg::MODE_FLASH_RED: return {bl, 1'b0};
            status_led_pkg::MODE_FLASH_GREEN: return {1'b0, bl};
            default: return 2'h1;
        endcase
    endfunction : drive

    function automatic logic [31:0] expect_word(input logic [AW-1:0] a);
        return status_led_pkg::MEM_PATTERN ^ 32'(a);
    endfunction : expect_word

    function automatic logic [31:0] pick(input logic [status_led_pkg::COND_W-1:0] c,
                                         input logic [31:0] d, input logic [31:0] b,
                                         input logic [31:0] f);
        if (c[status_led_pkg::BIT_DHCP_OK]) begin
            return d;
        end else if (c[status_led_pkg::BIT_BOOTP_OK]) begin
            return b;
        end
        return f;
    endfunction : pick

    // ==========================================================
    // Self-test memory
    assign mem_we = (r.st == status_led_pkg::ST_MEM_WR);
    assign mem_addr = r.cnt[AW-1:0];
    assign mem_wdata = expect_word(r.cnt[AW-1:0]);

    selftest_mem #(.DEPTH(MEM_DEPTH), .WIDTH(32)) u_mem (
        .hclk(hclk),
        .we(mem_we),
        .addr(mem_addr),
        .wdata(mem_wdata),
        .rdata(mem_rdata)
    );

    // All-green condition from the firmware flags
    assign all_good = r.cond[status_led_pkg::BIT_CFG_VALID] & r.cond[status_led_pkg::BIT_CONN_OPEN]
        & ~(r.cond[status_led_pkg::BIT_DUP_IP] | r.cond[status_led_pkg::BIT_CONN_FAULT]
        | r.cond[status_led_pkg::BIT_ERR_RECOV] | r.cond[status_led_pkg::BIT_ERR_UNREC]
        | r.cond[status_led_pkg::BIT_LBUS_FAULT]);

    // ==========================================================
    // Next-state logic
    always_comb begin
        logic [31:0] rd;
        logic [status_led_pkg::IRQ_W-1:0] ev;
        logic [status_led_pkg::IRQ_W-1:0] clr;
        logic last;
        rd = 32'h0000_0000;
        ev = '0;
        clr = '0;
        last = 1'b0;
        n = r;

        // Blink prescaler, equal high and low halves
        if (r.blink_cnt == 32'(BLINK_HALF - 1)) begin
            n.blink_cnt = 32'h0000_0000;
            n.blink = ~r.blink;
        end else begin
            n.blink_cnt = r.blink_cnt + 32'h0000_0001;
        end

        // Start-up sequence and display
        case (r.st)
            status_led_pkg::ST_LAMP_RED: begin
                n.lamps = 6'h2a;
                last = (r.cnt == 32'(LAMP_STEP - 1));
                n.cnt = last ? 32'h0000_0000 : r.cnt + 32'h0000_0001;
                n.st = last ? status_led_pkg::ST_LAMP_GREEN : r.st;
            end
            status_led_pkg::ST_LAMP_GREEN: begin
                n.lamps = 6'h15;
                last = (r.cnt == 32'(LAMP_STEP - 1));
                n.cnt = last ? 32'h0000_0000 : r.cnt + 32'h0000_0001;
                n.st = last ? status_led_pkg::ST_MEM_WR : r.st;
            end
            status_led_pkg::ST_MEM_WR: begin
                n.lamps = 6'h00;
                last = (r.cnt == 32'(MEM_DEPTH - 1));
                n.cnt = last ? 32'h0000_0000 : r.cnt + 32'h0000_0001;
                n.st = last ? status_led_pkg::ST_MEM_RD : r.st;
            end
            status_led_pkg::ST_MEM_RD: begin
                // Read data lag the address by one cycle, so the check trails too
                n.chk_vld = 1'b1;
                n.chk_addr = r.cnt[AW-1:0];
                if (r.cnt != 32'(MEM_DEPTH - 1)) begin
                    n.cnt = r.cnt + 32'h0000_0001;
                end
                if (r.chk_vld && mem_rdata != expect_word(r.chk_addr)) begin
                    n.mem_fail = 1'b1;
                    ev[status_led_pkg::IRQ_MEM_FAIL] = 1'b1;
                end
                if (r.chk_vld && r.chk_addr == AW'(MEM_DEPTH - 1)) begin
                    n.st = status_led_pkg::ST_RUN;
                    n.chk_vld = 1'b0;
                    ev[status_led_pkg::IRQ_INIT_DONE] = 1'b1;
                end
            end
            status_led_pkg::ST_RUN: begin
                // Each lamp looks only at its own causes
                n.lamps[5:4] = drive(severity(r.cond[status_led_pkg::BIT_ERR_UNREC],
                    r.cond[status_led_pkg::BIT_ERR_RECOV],
                    ~r.cond[status_led_pkg::BIT_CFG_VALID]), r.blink);
                n.lamps[3:2] = drive(severity(r.cond[status_led_pkg::BIT_DUP_IP],
                    r.cond[status_led_pkg::BIT_CONN_FAULT],
                    ~r.cond[status_led_pkg::BIT_CONN_OPEN]), r.blink);
                n.lamps[1:0] = drive(severity(r.cond[status_led_pkg::BIT_LBUS_FAULT],
                    1'b0, 1'b0), r.blink);
                n.prev_good = all_good;
                if (r.prev_good && !all_good) begin
                    ev[status_led_pkg::IRQ_GREEN_LOST] = 1'b1;
                end
            end
            default: begin
                n.st = status_led_pkg::ST_LAMP_RED;
                n.cnt = 32'h0000_0000;
            end
        endcase

        // Bus write, data phase of the previous address phase
        if (r.wr_pend) begin
            if (r.wr_idx == status_led_pkg::OFS_COND[7:2]) begin
                n.cond = hwdata[status_led_pkg::COND_W-1:0];
            end else if (r.wr_idx == status_led_pkg::OFS_IRQ_CLR[7:2]) begin
                clr = hwdata[status_led_pkg::IRQ_W-1:0];
            end else if (r.wr_idx == status_led_pkg::OFS_IRQ_EN[7:2]) begin
                n.irq_en = hwdata[status_led_pkg::IRQ_W-1:0];
            end else if (r.wr_idx >= status_led_pkg::OFS_DHCP[7:2]
                    && r.wr_idx < status_led_pkg::OFS_BOOTP[7:2]) begin
                n.dhcp[2'(r.wr_idx - status_led_pkg::OFS_DHCP[7:2])] = hwdata;
            end else if (r.wr_idx >= status_led_pkg::OFS_BOOTP[7:2]
                    && r.wr_idx < status_led_pkg::OFS_ACT[7:2]) begin
                n.bootp[2'(r.wr_idx - status_led_pkg::OFS_BOOTP[7:2])] = hwdata;
            end
        end

        // Sticky events; a new event beats a clear in the same cycle
        n.irq_stat = (r.irq_stat & ~clr) | ev;
        n.irq = |(n.irq_stat & n.irq_en);

        // Address phase: zero wait, read word sampled from the updated copy, state word from the current one
        n.rdy = 1'b1;
        n.wr_pend = 1'b0;
        if (hsel && htrans[1] && hready) begin
            n.wr_pend = hwrite && (haddr[31:8] == 24'h00_0000);
            n.wr_idx = haddr[7:2];
            if (!hwrite && haddr[31:8] == 24'h00_0000) begin
                if (haddr[7:2] == status_led_pkg::OFS_COND[7:2]) begin
                    rd = 32'(n.cond);
                end else if (haddr[7:2] == status_led_pkg::OFS_STATE[7:2]) begin
                    rd = {20'h0_0000, r.lamps, r.mem_fail, r.st};
                end else if (haddr[7:2] == status_led_pkg::OFS_IRQ_STAT[7:2]) begin
                    rd = 32'(n.irq_stat);
                end else if (haddr[7:2] == status_led_pkg::OFS_IRQ_EN[7:2]) begin
                    rd = 32'(n.irq_en);
                end else if (haddr[7:2] >= status_led_pkg::OFS_DHCP[7:2]
                        && haddr[7:2] < status_led_pkg::OFS_BOOTP[7:2]) begin
                    rd = n.dhcp[2'(haddr[7:2] - status_led_pkg::OFS_DHCP[7:2])];
                end else if (haddr[7:2] >= status_led_pkg::OFS_BOOTP[7:2]
                        && haddr[7:2] < status_led_pkg::OFS_ACT[7:2]) begin
                    rd = n.bootp[2'(haddr[7:2] - status_led_pkg::OFS_BOOTP[7:2])];
                end else if (haddr[7:2] == status_led_pkg::OFS_ACT[7:2]) begin
                    rd = pick(n.cond, n.dhcp[0], n.bootp[0], status_led_pkg::DEF_IP);
                end else if (haddr[7:2] == status_led_pkg::OFS_ACT[7:2] + 6'h01) begin
                    rd = pick(n.cond, n.dhcp[1], n.bootp[1], status_led_pkg::DEF_MASK);
                end else if (haddr[7:2] == status_led_pkg::OFS_ACT[7:2] + 6'h02) begin
                    rd = pick(n.cond, n.dhcp[2], n.bootp[2], status_led_pkg::DEF_GW);
                end
            end
            n.hrdata = rd;
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= '0;
            r.st <= status_led_pkg::ST_LAMP_RED;
            r.cond <= status_led_pkg::COND_RST;
            r.rdy <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign hreadyout = r.rdy;
    assign hresp = 1'b0;
    assign hrdata = r.hrdata;
    assign irq = r.irq;
    assign {ms_red, ms_green, ns_red, ns_green, lb_red, lb_green} = r.lamps;

    // ==========================================================
    // Checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic run;
    assign run = (r.st == status_led_pkg::ST_RUN);

    sequence s_lamp_red_end;
        r.st == status_led_pkg::ST_LAMP_RED && r.cnt == 32'(LAMP_STEP - 1);
    endsequence
    // Lamp outputs trail the state by one edge, so the green pattern is checked a cycle later
    sequence s_green_test;
        ms_green && ns_green && lb_green && !ms_red && !ns_red && !lb_red;
    endsequence

    all_green_a: assert property (run && all_good |=> r.lamps == 6'h15)
        else $error("lamps not all green");
    // Judged in the dark half of the blink: a lit flashing-green lamp looks steady green
    not_green_a: assert property (run && !all_good && !r.blink |=> r.lamps != 6'h15)
        else $error("all green despite a fault");
    unrec_red_a: assert property (run && r.cond[status_led_pkg::BIT_ERR_UNREC] |=> ms_red && !ms_green)
        else $error("module lamp not steady red");
    recov_flash_a: assert property (run && r.cond[5:4] == 2'h1 |=> ms_red == $past(r.blink) && !ms_green)
        else $error("module lamp not flashing red");
    no_cfg_a: assert property (run && r.cond[5:4] == 2'h0 && !r.cond[0] |=> !ms_red && ms_green == $past(r.blink))
        else $error("module lamp not flashing green");
    dup_red_a: assert property (run && r.cond[status_led_pkg::BIT_DUP_IP] |=> ns_red && !ns_green)
        else $error("network lamp not steady red");
    conn_fault_a: assert property (run && r.cond[3:1] == 3'h4 |=> ns_red == $past(r.blink) && !ns_green)
        else $error("network lamp not flashing red");
    no_conn_a: assert property (run && r.cond[3:1] == 3'h0 |=> !ns_red && ns_green == $past(r.blink))
        else $error("network lamp not flashing green");
    lbus_only_a: assert property (run |=> lb_red == $past(r.cond[6]) && lb_green == !$past(r.cond[6]))
        else $error("local bus lamp wrong");
    init_order_a: assert property (s_lamp_red_end |=> r.st == status_led_pkg::ST_LAMP_GREEN ##1 s_green_test)
        else $error("lamp test out of order");
    run_entry_a: assert property ($rose(run) |-> $past(r.st) == status_led_pkg::ST_MEM_RD)
        else $error("display started before memory test");
    blink_duty_a: assert property ($changed(r.blink) |-> $past(r.blink_cnt) == 32'(BLINK_HALF - 1))
        else $error("blink period wrong");
    fallback_a: assert property (n.cond[8:7] == 2'h0 && hsel && htrans[1] && hready && !hwrite
            && haddr == 32'(status_led_pkg::OFS_ACT) |=> hrdata == status_led_pkg::DEF_IP)
        else $error("default address not used");

endmodule : status_led

// file: lamp_model.sv
// Behavioural model of the three two-colour lamps that the block drives.
// Assumes one clock; it judges what each lamp showed over the last WIN samples.
module lamp_model #(
    parameter int WIN = 8
) (
    input wire logic hclk,
    input wire logic [2:0] red,
    input wire logic [2:0] green,
    output logic [5:0] seen,
    output logic [2:0] legal
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [WIN-1:0] hist_r [3];
    logic [WIN-1:0] hist_g [3];

    // ==========================================================
    // Classification
    // Result is {legal, mode}; a lamp lit in both colours is never legal
    function automatic logic [2:0] classify(input logic [WIN-1:0] r, input logic [WIN-1:0] g);
        int nr;
        int ng;
        nr = $countones(r);
        ng = $countones(g);
        if ((r & g) != '0) begin
            classify = 3'h0;
        end else if (nr == WIN && ng == 0) begin
            classify = 3'h7;
        end else if (nr == WIN / 2 && ng == 0) begin
            classify = 3'h6;
        end else if (ng == WIN / 2 && nr == 0) begin
            classify = 3'h5;
        end else if (ng == WIN && nr == 0) begin
            classify = 3'h4;
        end else begin
            classify = 3'h0;
        end
    endfunction : classify

    // ==========================================================
    // Sampling
    // A window of one full blink period sees exactly half on when the duty is even
    always @(posedge hclk) begin
        for (int k = 0; k < 3; k++) begin
            hist_r[k] <= {hist_r[k][WIN-2:0], red[k]};
            hist_g[k] <= {hist_g[k][WIN-2:0], green[k]};
        end
    end

    // Per-lamp verdict, index 2 is the module lamp
    always_comb begin
        for (int k = 0; k < 3; k++) begin
            {legal[k], seen[2*k +: 2]} = classify(hist_r[k], hist_g[k]);
        end
    end
endmodule : lamp_model

// file: tb_top.sv
// Self-checking bench for the status indicator block, driven over AHB-Lite.
// Assumes the lamp model is compiled first; one 200 MHz clock, short counts.
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin error_cnt++; $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int BLINK = 4;
    localparam int STEP = 3;
    localparam int DEPTH = 16;
    // Cause table: condition word and {ms, ns, lb} modes, green 0 .. red 3
    localparam logic [8:0] CONDS [11] = '{9'h005, 9'h025, 9'h015, 9'h004, 9'h007, 9'h00d,
                                          9'h001, 9'h045, 9'h030, 9'h00b, 9'h009};
    localparam logic [5:0] MODES [11] = '{6'h00, 6'h30, 6'h20, 6'h10, 6'h0c, 6'h08,
                                          6'h04, 6'h03, 6'h34, 6'h0c, 6'h08};
    localparam logic [31:0] ADR_EXP [9] = '{32'h0a00_0001, 32'hffff_0000, 32'h0a00_00fe,
                                            32'h0b00_0002, 32'hff00_0000, 32'h0b00_00fe,
                                            32'hc0a8_0145, 32'hffff_ff00, 32'h0000_0000};

    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hreadyout, hresp, irq;
    logic [31:0] hrdata;
    logic ms_red, ms_green, ns_red, ns_green, lb_red, lb_green;
    logic [5:0] seen;
    logic [2:0] legal;
    logic [5:0] lamps;
    int error_cnt = 0;
    int check_count = 0;

    // ==========================================================
    // Clock, design and lamp model
    always #2.5 hclk = ~hclk;
    assign lamps = {ms_red, ms_green, ns_red, ns_green, lb_red, lb_green};

    status_led #(.BLINK_HALF(BLINK), .LAMP_STEP(STEP), .MEM_DEPTH(DEPTH)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq),
        .ms_red(ms_red), .ms_green(ms_green), .ns_red(ns_red), .ns_green(ns_green),
        .lb_red(lb_red), .lb_green(lb_green));

    lamp_model #(.WIN(2 * BLINK)) lamp_far (
        .hclk(hclk), .red({ms_red, ns_red, lb_red}), .green({ms_green, ns_green, lb_green}),
        .seen(seen), .legal(legal));

    // ==========================================================
    // Closing and bus tasks
    task automatic report_and_stop();
        $display("TB: %0d mismatches in %0d comparisons", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop

    // Bounded wait; a slave that never answers ends the run
    task automatic await_ready();
        @(posedge hclk);
        for (int n = 0; hreadyout !== 1'b1; n++) begin
            if (n == 64) begin
                error_cnt++;
                report_and_stop();
            end
            @(posedge hclk);
        end
    endtask : await_ready

    // Entered just after a rising edge; read data taken at the data-phase edge
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        await_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        await_ready();
        q = hrdata;
        `CHK(hresp, 1'b0)
    endtask : bus

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic chk_rd(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        `CHK(q, e)
    endtask : chk_rd

    // ==========================================================
    // Scenarios
    // Start-up: lamps all red, all green, dark during the memory test
    task automatic startup();
        logic [31:0] q;
        for (int i = 0; i < 2 * STEP + 2 * DEPTH + 1; i++) begin
            @(posedge hclk);
            #1;
            `CHK(lamps, (i < STEP) ? 6'h2a : ((i < 2 * STEP) ? 6'h15 : 6'h00))
        end
        @(posedge hclk);
        bus(1'b0, 32'h0000_0004, 32'h0000_0000, q);
        `CHK(q[5:0], 6'h10)
        chk_rd(32'h0000_0008, 32'h0000_0001);
        wr(32'h0000_000c, 32'h0000_0001);
        chk_rd(32'h0000_0008, 32'h0000_0000);
    endtask : startup

    // Every cause alone and stacked; the model reports each lamp's pattern
    task automatic causes();
        for (int i = 0; i < 11; i++) begin
            wr(32'h0000_0000, {23'h0, CONDS[i]});
            repeat (2 * BLINK + 3) @(posedge hclk);
            `CHK(legal, 3'h7)
            `CHK(seen, MODES[i])
        end
    endtask : causes

    // Address words: DHCP first, then BOOTP, then the fixed fallback
    task automatic addr_choice();
        for (int j = 0; j < 6; j++) begin
            wr(32'h0000_0014 + 4 * j, ADR_EXP[j]);
        end
        chk_rd(32'h0000_0020, ADR_EXP[3]);
        for (int k = 0; k < 3; k++) begin
            wr(32'h0000_0000, (k == 0) ? 32'h0000_0180 : ((k == 1) ? 32'h0000_0100 : 32'h0000_0000));
            for (int j = 0; j < 3; j++) begin
                chk_rd(32'h0000_002c + 4 * j, ADR_EXP[3 * k + j]);
            end
        end
    endtask : addr_choice

    // Losing all-green raises the interrupt; mask, unmask, clear
    task automatic irq_path();
        wr(32'h0000_0000, 32'h0000_0005);
        repeat (3) @(posedge hclk);
        wr(32'h0000_000c, 32'h0000_0007);
        wr(32'h0000_0010, 32'h0000_0004);
        chk_rd(32'h0000_0010, 32'h0000_0004);
        repeat (3) @(posedge hclk);
        `CHK(irq, 1'b0)
        wr(32'h0000_0000, 32'h0000_0045);
        repeat (4) @(posedge hclk);
        `CHK(irq, 1'b1)
        chk_rd(32'h0000_0008, 32'h0000_0004);
        wr(32'h0000_0010, 32'h0000_0000);
        repeat (3) @(posedge hclk);
        `CHK(irq, 1'b0)
        wr(32'h0000_0010, 32'h0000_0004);
        repeat (3) @(posedge hclk);
        `CHK(irq, 1'b1)
        wr(32'h0000_000c, 32'h0000_0004);
        repeat (3) @(posedge hclk);
        `CHK(irq, 1'b0)
        chk_rd(32'h0000_0008, 32'h0000_0000);
        // Unmapped places read zero and swallow writes
        wr(32'h0000_003c, 32'hffff_ffff);
        chk_rd(32'h0000_003c, 32'h0000_0000);
        chk_rd(32'h0000_0100, 32'h0000_0000);
        chk_rd(32'h0000_0000, 32'h0000_0045);
    endtask : irq_path

    // ==========================================================
    // Main sequence
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        startup();
        causes();
        addr_choice();
        irq_path();
        report_and_stop();
    end
endmodule : tb_top
